// ===== bench/fcelc_host_model.sv
// Host controller model: issues APB transfers and polls status.
// Assumes the testbench calls its tasks after reset is released.
`timescale 1ns/100ps
module fcelc_host_model import fcelc_pkg::*; (
    // Clock
    input wire logic        sys_clk,
    // APB master outputs
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [7:0]      paddr,
    output logic [31:0]     pwdata,
    // APB slave answer
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    int timeouts = 0;

    // Idle bus at time zero.
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end

    // One transfer; the request holds until pready is seen at an edge, giving up after 50 edges.
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            timeouts++;
            $display("unexpected at %0t: no pready", $time);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Each poll is a fresh read, so status is refreshed every time.
    task automatic poll_ready();
        logic [31:0] q;
        logic e;
        int n;
        n = 0;
        do begin
            xfer(1'b0, OFS_STATUS, 32'h0, q, e);
            n++;
        end while (q[SW_READY] !== 1'b1 && n < 100);
        if (q[SW_READY] !== 1'b1) begin
            timeouts++;
            $display("unexpected at %0t: never ready", $time);
        end
    endtask
endmodule // fcelc_host_model

// ===== bench/fcelc_top_monitor.sv
// Checker for the flash command front end, watching only its APB port.
// Assumes zero wait states and prdata loaded in a read setup cycle.
`timescale 1ns/100ps
module fcelc_top_monitor import fcelc_pkg::*; (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // APB signals
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Phase and address decode shared by the properties.
    wire rd_setup = psel && !penable && !pwrite;
    wire acc      = psel && penable;
    wire bad      = (paddr > OFS_LOCK_QUERY) || (paddr[1:0] != 2'h0);
    wire st_rd    = rd_setup && (paddr == OFS_STATUS);

    a_ready_high: assert property (pready)
        else $error("pready dropped");
    a_err_unmapped: assert property (acc && bad |-> pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (acc && !bad |-> !pslverr)
        else $error("error on mapped access");
    a_err_outside: assert property (!acc |-> !pslverr)
        else $error("error outside access phase");
    a_bad_rd_zero: assert property (rd_setup && bad |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_code_rd_zero: assert property (
        rd_setup && paddr == OFS_CMD_CODE |=> prdata == 32'h0)
        else $error("command slot read not zero");
    a_status_fields: assert property (
        st_rd |=> (prdata & 32'hFFFFFF0B) == 32'h0)
        else $error("status spare bits set");
    a_susp_ready: assert property (
        st_rd |=> !(prdata[6] || prdata[2]) || prdata[7])
        else $error("suspend shown without ready");
    a_rcr_width: assert property (
        rd_setup && paddr == OFS_RCR |=> prdata[31:16] == 16'h0)
        else $error("configuration high bits set");
    a_mode_width: assert property (
        rd_setup && paddr == OFS_MODE |=> prdata[31:4] == 28'h0)
        else $error("mode spare bits set");
    a_data_holds: assert property (!rd_setup |=> $stable(prdata))
        else $error("read data moved outside setup");

    c_write: cover property (acc && pwrite && paddr == OFS_CMD_CODE);
    c_status: cover property (st_rd ##1 prdata[6]);
    c_unmapped: cover property (acc && bad);
endmodule // fcelc_top_monitor

bind fcelc_top fcelc_top_monitor i_fcelc_top_monitor (.sys_clk(sys_clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

// ===== bench/fcelc_top_tb_top.sv
// Testbench for the flash command front end, driving command cycles
// over APB through the host model. Assumes short operation counts.
`timescale 1ns/100ps
module fcelc_top_tb_top;
    import fcelc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          miscompares = 0;
    int          tests_run = 0;
    int          tnum = 0;

    // A 40 ns clock.
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // Long erase so suspend lands while it still runs.
    fcelc_top #(.ERASE_N(40), .PROG_N(5), .SUSP_N(3)) i_fcelc_top (
        .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    fcelc_host_model i_fcelc_host_model (.sys_clk(sys_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Masked comparison of a value read back.
    task automatic check(input logic [31:0] got, exp, mask);
        tests_run++;
        if ((got & mask) !== (exp & mask)) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, mask);
        logic [31:0] q;
        logic e;
        i_fcelc_host_model.xfer(1'b0, a, 32'h0, q, e);
        check(q, exp, mask);
    endtask

    // A command bus cycle: address lines first, then data lines.
    task automatic cmd(input logic [23:0] a, input logic [15:0] c);
        logic [31:0] q;
        logic e;
        i_fcelc_host_model.xfer(1'b1, OFS_CMD_ADDR, {8'h0, a}, q, e);
        i_fcelc_host_model.xfer(1'b1, OFS_CMD_CODE, {16'h0, c}, q, e);
    endtask

    task automatic lq(input logic [2:0] b, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        i_fcelc_host_model.xfer(1'b1, OFS_LOCK_QUERY, {29'h0, b}, q, e);
        rd(OFS_LOCK_QUERY, exp, 32'h73);
    endtask

    task automatic bad(input logic [7:0] a);
        logic [31:0] q;
        logic e;
        i_fcelc_host_model.xfer(1'b0, a, 32'h0, q, e);
        check({31'h0, e}, 32'h1, 32'h1);
        check(q, 32'h0, 32'hFFFFFFFF);
    endtask

    task automatic tend();
        tnum++;
        $display("test %0d done", tnum);
    endtask

    task automatic results();
        miscompares += i_fcelc_host_model.timeouts;
        $display("%0d checks, %0d mismatches", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(OFS_STATUS, 32'h80, 32'hFF);
        rd(OFS_RCR, 32'h8000, 32'hFFFF);
        lq(3'h0, 32'h01);
        tend();
        cmd(24'h400123, 16'h0020);
        rd(OFS_MODE, 32'h4, 32'hC);
        cmd(24'h400123, 16'h00D0);
        rd(OFS_LATCH_ADDR, 32'h400123, 32'hFFFFFF);
        rd(OFS_LATCH_DATA, 32'hD0, 32'hFFFF);
        rd(OFS_STATUS, 32'h0, 32'h80);
        cmd(24'h0, 16'h0060);
        rd(OFS_MODE, 32'h3, 32'hF);
        cmd(24'h0, 16'h00B0);
        i_fcelc_host_model.poll_ready();
        rd(OFS_STATUS, 32'hC0, 32'hFF);
        cmd(24'h0, 16'h0060);
        cmd(24'h0, 16'h002F);
        rd(OFS_STATUS, 32'hC0, 32'hFF);
        lq(3'h0, 32'h01);
        cmd(24'h0, 16'h00D0);
        rd(OFS_STATUS, 32'h0, 32'hC4);
        i_fcelc_host_model.poll_ready();
        rd(OFS_STATUS, 32'h80, 32'hFF);
        tend();
        cmd(24'h0, 16'h0020);
        cmd(24'h0, 16'h00FF);
        rd(OFS_STATUS, 32'hB0, 32'hFF);
        rd(OFS_MODE, 32'h1, 32'h1);
        cmd(24'h0, 16'h0070);
        rd(OFS_STATUS, 32'hB0, 32'hFF);
        cmd(24'h0, 16'h0050);
        rd(OFS_STATUS, 32'h80, 32'hFF);
        cmd(24'h0, 16'h00FF);
        rd(OFS_MODE, 32'h0, 32'h1);
        rd(OFS_CMD_CODE, 32'h0, 32'hFFFFFFFF);
        tend();
        cmd(24'h600000, 16'h0060);
        rd(OFS_MODE, 32'hC, 32'hC);
        cmd(24'h600000, 16'h002F);
        lq(3'h3, 32'h33);
        cmd(24'h600000, 16'h0060);
        cmd(24'h600000, 16'h00D0);
        lq(3'h3, 32'h33);
        cmd(24'h200000, 16'h0060);
        cmd(24'h200000, 16'h00D0);
        lq(3'h1, 32'h10);
        cmd(24'h200000, 16'h0060);
        cmd(24'h200000, 16'h0001);
        lq(3'h1, 32'h11);
        tend();
        cmd(24'h0, 16'h0060);
        cmd(24'h0, 16'h0055);
        rd(OFS_STATUS, 32'hB0, 32'hFF);
        cmd(24'h0, 16'h0050);
        cmd(24'h00ABCD, 16'h0060);
        cmd(24'h00ABCD, 16'h0003);
        rd(OFS_RCR, 32'hABCD, 32'hFFFF);
        rd(OFS_MODE, 32'h0, 32'h1);
        tend();
        cmd(24'h000080, 16'h00C0);
        rd(OFS_MODE, 32'h8, 32'hC);
        cmd(24'h000080, 16'h1234);
        rd(OFS_LATCH_ADDR, 32'h80, 32'hFFFFFF);
        rd(OFS_LATCH_DATA, 32'h1234, 32'hFFFF);
        i_fcelc_host_model.poll_ready();
        bad(8'h20);
        bad(8'h02);
        tend();
        results();
    end
endmodule // fcelc_top_tb_top

// ===== rtl/fcelc_lock.sv
// Per-block lock table: locked and locked-down bits for each block.
// Assumes one change request per cycle from the front end.
`timescale 1ns/100ps
module fcelc_lock import fcelc_pkg::*; #(
    parameter int NBLK_W = BLK_W
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // Change request
    input  fcelc_lkop_t            lk_op,
    input  wire logic [NBLK_W-1:0] lk_blk,
    // Query
    input  wire logic [NBLK_W-1:0] qry_blk,
    output logic      [1:0]        qry_state
);

    localparam int NBLK = 1 << NBLK_W;

    logic [1:0] blk_q [NBLK];

    // One entry per block; lock-down is left only through reset.
    genvar g;
    generate
        for (g = 0; g < NBLK; g++) begin : g_blk
            logic hit;
            assign hit = (lk_blk == NBLK_W'(g));
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    blk_q[g] <= LOCK_RST;
                end else if (hit) begin
                    case (lk_op)
                        LK_LOCK:   blk_q[g][0] <= 1'b1;
                        LK_UNLOCK: begin
                            if (!blk_q[g][1]) begin
                                blk_q[g][0] <= 1'b0;
                            end
                        end
                        LK_DOWN:   blk_q[g] <= 2'b11;
                        default:   blk_q[g] <= blk_q[g];
                    endcase
                end
            end
        end
    endgenerate

    // Bit 1 is lock-down, bit 0 is locked.
    assign qry_state = blk_q[qry_blk];

endmodule // fcelc_lock

// ===== rtl/fcelc_pkg.sv
// Package for the flash command front end: command codes, status bit
// positions, APB register offsets, reset values, states and carriers.
// Assumes a single 25 MHz system clock and an APB master outside.
package fcelc_pkg;

    // Bus widths of the modelled flash command port.
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BLK_W  = 3;

    // Command codes written on the data lines.
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
    localparam logic [7:0] CMD_SETUP_60    = 8'h60;
    localparam logic [7:0] CMD_LOCK        = 8'h01;
    localparam logic [7:0] CMD_LOCKDOWN    = 8'h2F;
    localparam logic [7:0] CMD_PROT_SETUP  = 8'hC0;
    localparam logic [7:0] CMD_RCR_SET     = 8'h03;
    localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;

    // Bit positions inside the status word.
    localparam int SW_READY    = 7;
    localparam int SW_ERS_SUSP = 6;
    localparam int SW_ERS_ERR  = 5;
    localparam int SW_PRG_ERR  = 4;
    localparam int SW_PRG_SUSP = 2;

    // APB register byte offsets.
    localparam logic [7:0] OFS_CMD_ADDR   = 8'h00;
    localparam logic [7:0] OFS_CMD_CODE   = 8'h04;
    localparam logic [7:0] OFS_STATUS     = 8'h08;
    localparam logic [7:0] OFS_RCR        = 8'h0C;
    localparam logic [7:0] OFS_MODE       = 8'h10;
    localparam logic [7:0] OFS_LATCH_ADDR = 8'h14;
    localparam logic [7:0] OFS_LATCH_DATA = 8'h18;
    localparam logic [7:0] OFS_LOCK_QUERY = 8'h1C;

    // Reset values.
    localparam logic [15:0] RCR_RST       = 16'h8000;
    localparam logic [1:0]  LOCK_RST      = 2'h1;

    // Internal operation timing in clock cycles.
    localparam int ERASE_CYC = 2000;
    localparam int PROG_CYC  = 200;
    localparam int SUSP_CYC  = 20;

    // Front end pending state, Gray coded along the usual path.
    typedef enum logic [1:0] {
        FE_IDLE  = 2'b00,
        FE_ERASE = 2'b01,
        FE_SET60 = 2'b11,
        FE_PROT  = 2'b10
    } fcelc_fe_t;

    // Write state machine states, Gray coded.
    typedef enum logic [1:0] {
        WS_IDLE    = 2'b00,
        WS_RUN     = 2'b01,
        WS_SUSPING = 2'b11,
        WS_SUSP    = 2'b10
    } fcelc_ws_t;

    // Read output selection.
    typedef enum logic {
        RD_ARRAY  = 1'b0,
        RD_STATUS = 1'b1
    } fcelc_rd_t;

    // Block lock change request.
    typedef enum logic [1:0] {
        LK_NONE   = 2'b00,
        LK_LOCK   = 2'b01,
        LK_UNLOCK = 2'b10,
        LK_DOWN   = 2'b11
    } fcelc_lkop_t;

    // One command bus write cycle: address and data lines.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fcelc_cycle_t;

    // Write state machine report to the front end.
    typedef struct packed {
        logic busy;
        logic susp_erase;
        logic susp_prog;
        logic op_erase;
    } fcelc_wsm_st_t;

endpackage

// ===== rtl/fcelc_top.sv
// Flash command front end for erase, suspend, locking, protection
// register programming and read configuration, behind an APB slave.
// Assumes an APB master on sys_clk; command cycles are APB writes.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps

// Contract
// - Code 20h arms erase; a following D0h confirm erases the block.
// - Anything but D0h after erase setup sets bits 4,5, status mode.
// - Erase confirm latches address and data; that block gets erased.
// - While erasing, only read-status and suspend are accepted.
// - Code B0h suspends the running program or erase.
// - Suspended shows ready bit 7 with bit 2 or bit 6.
// - Suspend holds until resume or reset.
// - D0h while suspended resumes the operation.
// - After 60h only 01h, D0h, 2Fh, 03h are valid; else bits 4,5.
// - 01h after 60h locks the addressed block.
// - D0h after 60h unlocks, except a locked-down block.
// - 2Fh after 60h locks down the addressed block.
// - C0h arms protection program; second cycle latches and starts.
// - After 60h, anything but 01h, D0h, 2Fh or 03h flags a sequence error.
// - 03h after 60h stores address bits 15..0 as configuration.
// - After a configuration write, reads return array data.
// - Code 50h clears the error bits.
// - Code 70h selects status read; so do program and erase.
module fcelc_top import fcelc_pkg::*; #(
    parameter int ERASE_N = ERASE_CYC,
    parameter int PROG_N  = PROG_CYC,
    parameter int SUSP_N  = SUSP_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // Block number of a flash address, used for locking.
    function automatic logic [BLK_W-1:0] blk_of(
        input logic [ADDR_W-1:0] a);
        blk_of = a[ADDR_W-1 -: BLK_W];
    endfunction

    fcelc_fe_t         fe_q, fe_d;
    fcelc_rd_t         rd_q, rd_d;
    fcelc_cycle_t      latch_q, latch_d;
    fcelc_wsm_st_t     wst;
    fcelc_lkop_t       lk_op;
    logic [ADDR_W-1:0] cmd_addr_q;
    logic [BLK_W-1:0]  qry_blk_q;
    logic [15:0]       rcr_q, rcr_d;
    logic              prg_err_q, ers_err_q;
    logic [31:0]       prdata_q;
    logic [1:0]        qry_state;
    logic [BLK_W-1:0]  lk_blk;

    // Bus phase decode; the slave never inserts wait states.
    logic        access, setup, wr_acc, mapped, cmd_wr;
    logic [7:0]  code;
    logic [15:0] dq;
    assign access = psel && penable;
    assign setup  = psel && !penable;
    assign wr_acc = access && pwrite;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_LOCK_QUERY);
    assign cmd_wr = wr_acc && (paddr == OFS_CMD_CODE);
    assign code   = pwdata[7:0];
    assign dq     = pwdata[15:0];

    // Command classification.
    logic suspended, busy, accept;
    assign busy      = wst.busy;
    assign suspended = wst.susp_erase || wst.susp_prog;
    // A running operation hears only status reads and suspend.
    assign accept    = cmd_wr && (!busy || code == CMD_READ_STATUS ||
                                  code == CMD_SUSPEND);

    // Requests toward the write state machine.
    logic start_erase, start_prog, suspend_req, resume_req;
    assign start_erase = accept && (fe_q == FE_ERASE) &&
                         (code == CMD_CONFIRM);
    assign start_prog  = accept && (fe_q == FE_PROT);
    assign suspend_req = accept && busy &&
                         (code == CMD_SUSPEND);
    assign resume_req  = accept && suspended && (fe_q == FE_IDLE) &&
                         (code == CMD_CONFIRM);

    // Lock change decoded from the second code after 60h.
    logic in_set60;
    assign in_set60 = accept && (fe_q == FE_SET60);
    assign lk_blk   = blk_of(cmd_addr_q);
    assign lk_op    = !in_set60              ? LK_NONE :
                      (code == CMD_LOCK)     ? LK_LOCK :
                      (code == CMD_CONFIRM)  ? LK_UNLOCK :
                      (code == CMD_LOCKDOWN) ? LK_DOWN :
                                               LK_NONE;

    // Sequence errors: bad second code after erase or 60h setup.
    logic seq_err, clr_err;
    assign seq_err = accept &&
                     (((fe_q == FE_ERASE) && code != CMD_CONFIRM) ||
                      (in_set60 && lk_op == LK_NONE &&
                       code != CMD_RCR_SET));
    assign clr_err = accept && (fe_q == FE_IDLE) && !busy &&
                     (code == CMD_CLR_STATUS);

    // Front end sequencing, read mode and latches.
    always_comb begin
        fe_d    = fe_q;
        rd_d    = rd_q;
        latch_d = latch_q;
        rcr_d   = rcr_q;
        if (accept) begin
            case (fe_q)
                FE_IDLE: begin
                    if (code == CMD_READ_STATUS) begin
                        rd_d = RD_STATUS;
                    end else if (busy) begin
                        rd_d = rd_q;
                    end else if (code == CMD_READ_ARRAY) begin
                        rd_d = RD_ARRAY;
                    end else if (resume_req) begin
                        rd_d = RD_STATUS;
                    end else if (suspended) begin
                        // No new operation may start over a suspended one.
                        fe_d = FE_IDLE;
                    end else if (code == CMD_ERASE_SETUP) begin
                        fe_d = FE_ERASE;
                    end else if (code == CMD_SETUP_60) begin
                        fe_d = FE_SET60;
                    end else if (code == CMD_PROT_SETUP) begin
                        fe_d = FE_PROT;
                    end
                end
                FE_ERASE: begin
                    fe_d = FE_IDLE;
                    rd_d = RD_STATUS;
                    if (code == CMD_CONFIRM) begin
                        latch_d.addr = cmd_addr_q;
                        latch_d.data = dq;
                    end
                end
                FE_SET60: begin
                    fe_d = FE_IDLE;
                    if (code == CMD_RCR_SET) begin
                        rcr_d = cmd_addr_q[15:0];
                        rd_d  = RD_ARRAY;
                    end else if (seq_err) begin
                        rd_d = RD_STATUS;
                    end
                end
                FE_PROT: begin
                    fe_d         = FE_IDLE;
                    latch_d.addr = cmd_addr_q;
                    latch_d.data = dq;
                    rd_d         = RD_STATUS;
                end
                default: fe_d = FE_IDLE;
            endcase
        end
    end

    // Command front end registers.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fe_q    <= FE_IDLE;
            rd_q    <= RD_ARRAY;
            latch_q <= '0;
            rcr_q   <= RCR_RST;
        end else begin
            fe_q    <= fe_d;
            rd_q    <= rd_d;
            latch_q <= latch_d;
            rcr_q   <= rcr_d;
        end
    end

    // Error bits are sticky; a set in the clearing cycle still wins.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prg_err_q <= 1'b0;
            ers_err_q <= 1'b0;
        end else begin
            prg_err_q <= (prg_err_q && !clr_err) || seq_err;
            ers_err_q <= (ers_err_q && !clr_err) || seq_err;
        end
    end

    // Address lines and lock query index, written by software.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_addr_q <= '0;
            qry_blk_q  <= '0;
        end else begin
            if (wr_acc && paddr == OFS_CMD_ADDR) begin
                cmd_addr_q <= pwdata[ADDR_W-1:0];
            end
            if (wr_acc && paddr == OFS_LOCK_QUERY) begin
                qry_blk_q <= pwdata[BLK_W-1:0];
            end
        end
    end

    // Status word; ready also shows while suspended.
    logic [7:0] status_word;
    always_comb begin
        status_word              = 8'h00;
        status_word[SW_READY]    = !busy;
        status_word[SW_ERS_SUSP] = wst.susp_erase;
        status_word[SW_ERS_ERR]  = ers_err_q;
        status_word[SW_PRG_ERR]  = prg_err_q;
        status_word[SW_PRG_SUSP] = wst.susp_prog;
    end

    // Read data selection, registered in the setup phase.
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            OFS_CMD_ADDR:   rd_mux = 32'(cmd_addr_q);
            OFS_STATUS:     rd_mux = {24'h000000, status_word};
            OFS_RCR:        rd_mux = {16'h0000, rcr_q};
            OFS_MODE:       rd_mux = {28'h0000000, fe_q, busy, rd_q};
            OFS_LATCH_ADDR: rd_mux = 32'(latch_q.addr);
            OFS_LATCH_DATA: rd_mux = {16'h0000, latch_q.data};
            OFS_LOCK_QUERY: rd_mux = {28'h0000000, 2'b00,
                                      qry_state} |
                                     (32'(qry_blk_q) << 4);
            default:        rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    // Zero wait states; unmapped or misaligned access reports an error.
    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // Timing engine for erase and protection register programming.
    fcelc_wsm #(
        .ERASE_N (ERASE_N),
        .PROG_N  (PROG_N),
        .SUSP_N  (SUSP_N)
    ) u_wsm (
        .sys_clk     (sys_clk),
        .rst_b       (rst_b),
        .start_erase (start_erase),
        .start_prog  (start_prog),
        .suspend_req (suspend_req),
        .resume_req  (resume_req),
        .wsm_st      (wst)
    );

    // Block lock table.
    fcelc_lock #(
        .NBLK_W (BLK_W)
    ) u_lock (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .lk_op     (lk_op),
        .lk_blk    (lk_blk),
        .qry_blk   (qry_blk_q),
        .qry_state (qry_state)
    );

endmodule // fcelc_top

// ===== rtl/fcelc_wsm.sv
// Write state machine: times an erase or program, handles suspend
// and resume. Assumes one-cycle start, suspend and resume pulses.
`timescale 1ns/100ps
module fcelc_wsm import fcelc_pkg::*; #(
    parameter int ERASE_N = ERASE_CYC,
    parameter int PROG_N  = PROG_CYC,
    parameter int SUSP_N  = SUSP_CYC,
    parameter int CNT_W   = 16
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    // Requests from the front end
    input  wire logic          start_erase,
    input  wire logic          start_prog,
    input  wire logic          suspend_req,
    input  wire logic          resume_req,
    // Report
    output fcelc_wsm_st_t      wsm_st
);

    fcelc_ws_t        state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] scnt_q, scnt_d;
    logic             op_erase_q, op_erase_d;

    // Next state; the remaining work count is frozen while suspended
    // so a resume continues rather than restarting the operation.
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        scnt_d     = scnt_q;
        op_erase_d = op_erase_q;
        case (state_q)
            WS_IDLE: begin
                if (start_erase) begin
                    state_d    = WS_RUN;
                    cnt_d      = CNT_W'(ERASE_N);
                    op_erase_d = 1'b1;
                end else if (start_prog) begin
                    state_d    = WS_RUN;
                    cnt_d      = CNT_W'(PROG_N);
                    op_erase_d = 1'b0;
                end
            end
            WS_RUN: begin
                if (suspend_req) begin
                    state_d = WS_SUSPING;
                    scnt_d  = CNT_W'(SUSP_N);
                end else if (cnt_q <= CNT_W'(1)) begin
                    state_d = WS_IDLE;
                    cnt_d   = '0;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            WS_SUSPING: begin
                if (scnt_q <= CNT_W'(1)) begin
                    state_d = WS_SUSP;
                end else begin
                    scnt_d = scnt_q - CNT_W'(1);
                end
            end
            WS_SUSP: begin
                // Only a resume leaves; reset acts asynchronously.
                if (resume_req) begin
                    state_d = WS_RUN;
                end
            end
            default: state_d = WS_IDLE;
        endcase
    end

    // State registers.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= WS_IDLE;
            cnt_q      <= '0;
            scnt_q     <= '0;
            op_erase_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            scnt_q     <= scnt_d;
            op_erase_q <= op_erase_d;
        end
    end

    // Report to the front end; suspended kind shows only once settled.
    assign wsm_st.busy       = (state_q == WS_RUN) ||
                               (state_q == WS_SUSPING);
    assign wsm_st.susp_erase = (state_q == WS_SUSP) && op_erase_q;
    assign wsm_st.susp_prog  = (state_q == WS_SUSP) && !op_erase_q;
    assign wsm_st.op_erase   = op_erase_q;

endmodule // fcelc_wsm
